/* File: bhr_pkg.sv */
package bhr_pkg;

  localparam int unsigned MAX_DEPTH = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned CAT_SLOTS = 7;

  // Depth register: reset value and legal-depth capability mask
  localparam logic [7:0] DEPTH_RST = 8'h08;
  localparam logic [7:0] DEPTH_CAP = 8'hFF;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_CTL = 12'h000;
  localparam logic [11:0] OFF_DEPTH = 12'h004;
  localparam logic [11:0] OFF_CAP = 12'h008;
  localparam logic [11:0] OFF_DBG = 12'h00C;
  localparam logic [11:0] OFF_STS = 12'h010;
  localparam logic [11:0] OFF_SEL = 12'h014;
  localparam logic [11:0] OFF_SRC = 12'h018;
  localparam logic [11:0] OFF_DST = 12'h01C;
  localparam logic [11:0] OFF_META = 12'h020;
  localparam logic [11:0] OFF_LER_SRC = 12'h024;
  localparam logic [11:0] OFF_LER_DST = 12'h028;
  localparam logic [11:0] OFF_LER_META = 12'h02C;

  // Control register fields
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_CS_BIT = 3;
  localparam int unsigned CTL_CAT_LSB = 16;
  localparam int unsigned CTL_OTHER_SLOT = 6;
  localparam logic [31:0] CTL_MASK = 32'h007F_0009;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;

  // Debug control fields
  localparam int unsigned DBG_FRZ_PMI_BIT = 0;
  localparam int unsigned DBG_FRZ_SMM_BIT = 1;

  // Status fields
  localparam int unsigned STS_FRZ_BIT = 0;

  // Branch category codes, shared by filter slots and metadata
  localparam logic [3:0] CAT_FLAG_TEST_BRANCH = 4'h0;
  localparam logic [3:0] CAT_IND_JMP = 4'h1;
  localparam logic [3:0] CAT_REL_JMP = 4'h2;
  localparam logic [3:0] CAT_IND_CALL = 4'h3;
  localparam logic [3:0] CAT_REL_CALL = 4'h4;
  localparam logic [3:0] CAT_RET = 4'h5;
  localparam logic [3:0] CAT_OTHER = 4'h8;

  // Kind of retired control transfer
  typedef enum logic [2:0] {
    EV_BRANCH = 3'b000,
    EV_BETWEEN = 3'b001,
    EV_RESUME = 3'b010,
    EV_DEBUG = 3'b011,
    EV_VMEXIT = 3'b100,
    EV_VMENTRY = 3'b101,
    EV_SMI = 3'b110,
    EV_LAUNCH = 3'b111
  } bhr_ev_t;

endpackage

/* File: bhr_recorder.sv */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module bhr_recorder
  import bhr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rt_valid,
  input wire logic [2:0] rt_kind,
  input wire logic [3:0] rt_cat,
  input wire logic rt_zero_disp,
  input wire logic rt_exc,
  input wire logic [31:0] rt_cur_ip,
  input wire logic [31:0] rt_next_ip,
  input wire logic [31:0] rt_tgt_ip,
  input wire logic in_sysmgmt,
  input wire logic in_enclave,
  input wire logic perf_irq_pend,
  output logic record_enable,
  output logic record_frozen_flag
);

  typedef struct packed {
    logic [MAX_DEPTH-1:0][31:0] src;
    logic [MAX_DEPTH-1:0][31:0] dst;
    logic [MAX_DEPTH-1:0][3:0] cat;
    logic [31:0] ler_src;
    logic [31:0] ler_dst;
    logic [3:0] ler_cat;
    logic [31:0] last_src;
    logic [31:0] last_dst;
    logic [3:0] last_cat;
    logic last_vld;
    logic [31:0] ctl;
    logic [7:0] depth;
    logic frz_pmi;
    logic frz_smm;
    logic frozen;
    logic [7:0] sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bhr_state_t;

  bhr_state_t state_r;
  bhr_state_t state_nxt;

  bhr_ev_t kind;
  logic setup;
  logic access;
  logic entry_hit;
  logic entry_fault;
  logic depth_bad;
  logic unmapped;
  logic suspend;
  logic kind_ok;
  logic cat_ok;
  logic allowed;
  logic rec;
  logic pop;
  logic [3:0] rcat;
  logic [31:0] new_src;
  logic [IDX_W-1:0] sel_idx;

  assign kind = bhr_ev_t'(rt_kind);
  // Low bits suffice: wider selects fault before any use
  assign sel_idx = state_r.sel[IDX_W-1:0];

  always_comb
  begin
    state_nxt = state_r;
    setup = psel & ~penable;
    access = psel & penable & state_r.pready;
    entry_hit = (paddr == OFF_SRC) | (paddr == OFF_DST) | (paddr == OFF_META);
    // Compare on the full select so wide indices fault too
    entry_fault = entry_hit & (state_r.sel >= state_r.depth);
    // Capability bit n marks depth n+1 as legal
    depth_bad = (pwdata[7:0] == 8'h00) | (pwdata[7:0] > DEPTH_RST) |
                ~DEPTH_CAP[pwdata[2:0] - 3'd1];
    unmapped = 1'b0;
    state_nxt.pready = setup;
    state_nxt.pslverr = 1'b0;
    state_nxt.prdata = 32'h0000_0000;

    // Answer prepared in setup, presented during access
    if (setup)
    begin
      case (paddr)
        OFF_CTL:
        begin
          state_nxt.prdata = state_r.ctl;
        end
        OFF_DEPTH:
        begin
          state_nxt.prdata = {24'h00_0000, state_r.depth};
        end
        OFF_CAP:
        begin
          state_nxt.prdata = {24'h00_0000, DEPTH_CAP};
        end
        OFF_DBG:
        begin
          state_nxt.prdata = {30'h0000_0000, state_r.frz_smm, state_r.frz_pmi};
        end
        OFF_STS:
        begin
          state_nxt.prdata = {31'h0000_0000, state_r.frozen};
        end
        OFF_SEL:
        begin
          state_nxt.prdata = {24'h00_0000, state_r.sel};
        end
        OFF_SRC:
        begin
          state_nxt.prdata = state_r.src[sel_idx];
        end
        OFF_DST:
        begin
          state_nxt.prdata = state_r.dst[sel_idx];
        end
        OFF_META:
        begin
          state_nxt.prdata = {28'h000_0000, state_r.cat[sel_idx]};
        end
        OFF_LER_SRC:
        begin
          state_nxt.prdata = state_r.ler_src;
        end
        OFF_LER_DST:
        begin
          state_nxt.prdata = state_r.ler_dst;
        end
        OFF_LER_META:
        begin
          state_nxt.prdata = {28'h000_0000, state_r.ler_cat};
        end
        default:
        begin
          unmapped = 1'b1;
        end
      endcase
      state_nxt.pslverr = unmapped | entry_fault | (pwrite & (paddr == OFF_CAP)) |
                          (pwrite & (paddr == OFF_DEPTH) & depth_bad);
      if (state_nxt.pslverr)
      begin
        state_nxt.prdata = 32'h0000_0000;
      end
    end

    // Writes land on the access edge; refused ones never do
    if (access & pwrite & ~state_r.pslverr)
    begin
      case (paddr)
        OFF_CTL:
        begin
          state_nxt.ctl = pwdata & CTL_MASK;
        end
        OFF_DEPTH:
        begin
          state_nxt.depth = pwdata[7:0];
          state_nxt.src = '0;
          state_nxt.dst = '0;
          state_nxt.cat = '0;
        end
        OFF_DBG:
        begin
          state_nxt.frz_pmi = pwdata[DBG_FRZ_PMI_BIT];
          state_nxt.frz_smm = pwdata[DBG_FRZ_SMM_BIT];
        end
        OFF_STS:
        begin
          if (pwdata[STS_FRZ_BIT])
          begin
            state_nxt.frozen = 1'b0;
          end
        end
        OFF_SEL:
        begin
          state_nxt.sel = pwdata[7:0];
        end
        OFF_SRC:
        begin
          state_nxt.src[sel_idx] = pwdata;
        end
        OFF_DST:
        begin
          state_nxt.dst[sel_idx] = pwdata;
        end
        OFF_META:
        begin
          state_nxt.cat[sel_idx] = pwdata[3:0];
        end
        OFF_LER_SRC:
        begin
          state_nxt.ler_src = pwdata;
        end
        OFF_LER_DST:
        begin
          state_nxt.ler_dst = pwdata;
        end
        OFF_LER_META:
        begin
          state_nxt.ler_cat = pwdata[3:0];
        end
        default:
        begin
          state_nxt.ctl = state_r.ctl;
        end
      endcase
    end

    // Set beats a clear arriving in the same cycle
    if (perf_irq_pend & state_r.frz_pmi)
    begin
      state_nxt.frozen = 1'b1;
    end

    // Classify the retired transfer
    suspend = in_sysmgmt | in_enclave;
    rcat = (kind == EV_RESUME) ? CAT_OTHER : rt_cat;
    case (kind)
      EV_BRANCH:
      begin
        kind_ok = ~rt_zero_disp;
      end
      EV_BETWEEN:
      begin
        kind_ok = 1'b1;
      end
      EV_RESUME:
      begin
        kind_ok = ~state_r.frz_smm;
      end
      default:
      begin
        kind_ok = 1'b0;
      end
    endcase
    if (rcat[3])
    begin
      cat_ok = state_r.ctl[CTL_CAT_LSB + CTL_OTHER_SLOT];
    end
    else if (rcat[2:1] == 2'b11)
    begin
      cat_ok = 1'b0;
    end
    else
    begin
      cat_ok = state_r.ctl[CTL_CAT_LSB + 32'(rcat[2:0])];
    end
    allowed = rt_valid & state_r.ctl[CTL_EN_BIT] & ~state_r.frozen & ~suspend;
    rec = allowed & kind_ok & cat_ok;
    pop = rec & state_r.ctl[CTL_CS_BIT] & (rcat == CAT_RET);
    case (kind)
      EV_BETWEEN: new_src = rt_next_ip;
      EV_RESUME: new_src = rt_tgt_ip;
      default: new_src = rt_cur_ip;
    endcase

    if (pop)
    begin
      // Loop stops short of the last slot so no index runs past the array
      for (int i = 0; i < MAX_DEPTH - 1; i++)
      begin
        if (32'(i + 1) < 32'(state_r.depth))
        begin
          state_nxt.src[i] = state_nxt.src[i + 1];
          state_nxt.dst[i] = state_nxt.dst[i + 1];
          state_nxt.cat[i] = state_nxt.cat[i + 1];
        end
      end
      for (int i = 0; i < MAX_DEPTH; i++)
      begin
        if (32'(i + 1) == 32'(state_r.depth))
        begin
          state_nxt.src[i] = 32'h0000_0000;
          state_nxt.dst[i] = 32'h0000_0000;
          state_nxt.cat[i] = 4'h0;
        end
      end
    end
    else if (rec)
    begin
      // Ring behaviour: the oldest entry falls off the end
      for (int i = MAX_DEPTH - 1; i > 0; i--)
      begin
        if (32'(i) < 32'(state_r.depth))
        begin
          state_nxt.src[i] = state_nxt.src[i - 1];
          state_nxt.dst[i] = state_nxt.dst[i - 1];
          state_nxt.cat[i] = state_nxt.cat[i - 1];
        end
      end
      state_nxt.src[0] = new_src;
      state_nxt.dst[0] = rt_tgt_ip;
      state_nxt.cat[0] = rcat;
    end

    // Last-event record takes the branch held before the exception
    if (allowed & rt_exc & state_r.last_vld)
    begin
      state_nxt.ler_src = state_r.last_src;
      state_nxt.ler_dst = state_r.last_dst;
      state_nxt.ler_cat = state_r.last_cat;
    end
    if (rec)
    begin
      state_nxt.last_src = new_src;
      state_nxt.last_dst = rt_tgt_ip;
      state_nxt.last_cat = rcat;
      state_nxt.last_vld = 1'b1;
    end

    // Debug transfers and secure launch drop recording until re-armed
    if (rt_valid & (kind == EV_DEBUG))
    begin
      state_nxt.ctl[CTL_EN_BIT] = 1'b0;
    end
    if (rt_valid & (kind == EV_LAUNCH))
    begin
      state_nxt.ctl = CTL_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= '0;
      state_r.ctl <= CTL_RST;
      state_r.depth <= DEPTH_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign record_enable = state_r.ctl[CTL_EN_BIT];
  assign record_frozen_flag = state_r.frozen;

endmodule

`default_nettype wire

/* File: bhr_recorder_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module bhr_chk
  import bhr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rt_valid,
  input wire logic [2:0] rt_kind,
  input wire logic perf_irq_pend,
  input wire logic record_enable,
  input wire logic record_frozen_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready or zero data");
  property p_en;
    $rose(record_enable) |-> $past(psel && penable && pwrite && paddr == OFF_CTL && pwdata[0]);
  endproperty
  a_en: assert property (p_en) else $error("enable rose without write");
  property p_dbg; rt_valid && (rt_kind == 3'd3 || rt_kind == 3'd7) |=> !record_enable; endproperty
  a_dbg: assert property (p_dbg) else $error("enable kept after debug");
  property p_frz; $rose(record_frozen_flag) |-> $past(perf_irq_pend); endproperty
  a_frz: assert property (p_frz) else $error("frozen without interrupt");
  property p_hold;
    record_frozen_flag && !(psel && penable && pwrite && paddr == OFF_STS && pwdata[0])
      |=> record_frozen_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("frozen flag dropped");
  property p_dep;
    psel && penable && pwrite && paddr == OFF_DEPTH && (pwdata[7:0] == 8'h0 || pwdata[7:0] > 8'h8)
      |-> pslverr;
  endproperty
  a_dep: assert property (p_dep) else $error("illegal depth taken");
endmodule
bind bhr_recorder bhr_chk u_chk(.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rt_valid(rt_valid), .rt_kind(rt_kind),
  .perf_irq_pend(perf_irq_pend), .record_enable(record_enable),
  .record_frozen_flag(record_frozen_flag));
`default_nettype wire

/* File: bhr_retire_src.sv */
`timescale 1ns/1ns
`default_nettype none
module bhr_retire_src
(
  input wire logic clk_sys,
  output logic rt_valid,
  output logic [2:0] rt_kind,
  output logic [3:0] rt_cat,
  output logic rt_zero_disp,
  output logic rt_exc,
  output logic [31:0] rt_cur_ip,
  output logic [31:0] rt_next_ip,
  output logic [31:0] rt_tgt_ip
);
  initial
  begin
    {rt_valid, rt_kind, rt_cat, rt_zero_disp, rt_exc} = '0;
    {rt_cur_ip, rt_next_ip, rt_tgt_ip} = '0;
  end
  task automatic send(input logic [2:0] k, input logic [3:0] c, input logic zd, input logic ex,
    input logic [31:0] a, input logic [31:0] n, input logic [31:0] t);
    {rt_valid, rt_kind, rt_cat, rt_zero_disp, rt_exc} <= {1'b1, k, c, zd, ex};
    {rt_cur_ip, rt_next_ip, rt_tgt_ip} <= {a, n, t};
    @(posedge clk_sys);
    rt_valid <= 1'b0;
    // Stale lines inverted so they never pass for a fresh transfer
    {rt_cur_ip, rt_next_ip, rt_tgt_ip} <= ~{a, n, t};
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: branch_history_recorder_test.sv */
`timescale 1ns/1ns
`default_nettype none
module branch_history_recorder_test;
  import bhr_pkg::*;
  typedef struct packed {logic [31:0] s; logic [31:0] d; logic [3:0] c;} bhr_ent_t;
  logic clk_sys = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic in_sysmgmt = 0;
  logic in_enclave = 0;
  logic perf_irq_pend = 0;
  logic [31:0] prdata, rt_cur_ip, rt_next_ip, rt_tgt_ip;
  logic pready, pslverr, rt_valid, rt_zero_disp, rt_exc, record_enable, record_frozen_flag;
  logic [2:0] rt_kind;
  logic [3:0] rt_cat;
  bhr_ent_t me [8];
  bhr_ent_t le;
  int dep = 8;
  int n_fail = 0;
  int compares = 0;
  logic cs = 0;
  always #10 clk_sys = ~clk_sys;
  bhr_recorder u_dut(.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rt_valid(rt_valid), .rt_kind(rt_kind), .rt_cat(rt_cat),
    .rt_zero_disp(rt_zero_disp), .rt_exc(rt_exc), .rt_cur_ip(rt_cur_ip),
    .rt_next_ip(rt_next_ip), .rt_tgt_ip(rt_tgt_ip), .in_sysmgmt(in_sysmgmt),
    .in_enclave(in_enclave), .perf_irq_pend(perf_irq_pend), .record_enable(record_enable),
    .record_frozen_flag(record_frozen_flag));
  bhr_retire_src u_ret(.clk_sys(clk_sys), .rt_valid(rt_valid), .rt_kind(rt_kind),
    .rt_cat(rt_cat), .rt_zero_disp(rt_zero_disp), .rt_exc(rt_exc), .rt_cur_ip(rt_cur_ip),
    .rt_next_ip(rt_next_ip), .rt_tgt_ip(rt_tgt_ip));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] x, input logic xe);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    if (!w) chk(prdata, x);
    chk({31'h0, pslverr}, {31'h0, xe});
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ap(1'b1, a, d, '0, 1'b0);
  endtask
  task automatic clr;
    foreach (me[i]) me[i] = '0;
  endtask
  task automatic tx(input logic [2:0] k, input logic [3:0] c, input logic zd, input logic ex,
    input logic y);
    logic [31:0] a, n, t;
    a = $urandom;
    n = $urandom;
    t = $urandom;
    u_ret.send(k, c, zd, ex, a, n, t);
    if (y && ex) le = me[0];
    if (y && cs && c == CAT_RET)
    begin
      for (int i = 0; i < dep - 1; i++) me[i] = me[i+1];
      me[dep-1] = '0;
    end
    else if (y)
    begin
      for (int i = dep - 1; i > 0; i--) me[i] = me[i-1];
      me[0] = '{(k == 3'd1) ? n : ((k == 3'd2) ? t : a), t, c};
    end
  endtask
  task automatic ce;
    for (int i = 0; i < dep; i++)
    begin
      wr(OFF_SEL, i);
      ap(1'b0, OFF_SRC, '0, me[i].s, 1'b0);
      ap(1'b0, OFF_DST, '0, me[i].d, 1'b0);
      ap(1'b0, OFF_META, '0, {28'h0, me[i].c}, 1'b0);
    end
  endtask
  initial
  begin
    #400000;
    n_fail++;
    results;
  end
  initial
  begin
    void'($urandom(32'hf84c_233c));
    clr;
    le = '0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    ap(1'b0, OFF_DEPTH, '0, 32'h0000_0008, 1'b0);
    ap(1'b0, OFF_CAP, '0, {24'h0, DEPTH_CAP}, 1'b0);
    ap(1'b1, OFF_CAP, 32'h0000_0000, '0, 1'b1);
    ap(1'b0, 12'h030, '0, '0, 1'b1);
    ce;
    $display("test reset done");
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, 32'h007F_0001);
    for (int j = 0; j < 6; j++) tx(3'd0, 4'(j), 1'b0, 1'b0, 1'b1);
    tx(3'd0, 4'h8 | 4'($urandom), 1'b0, 1'b0, 1'b1);
    tx(3'd1, CAT_OTHER, 1'b0, 1'b0, 1'b1);
    tx(3'd2, CAT_OTHER, 1'b0, 1'b0, 1'b1);
    tx(3'd0, CAT_REL_CALL, 1'b1, 1'b0, 1'b0);
    for (int k = 4; k < 7; k++) tx(3'(k), CAT_OTHER, 1'b0, 1'b0, 1'b0);
    tx(3'd0, CAT_OTHER, 1'b0, 1'b1, 1'b1);
    in_sysmgmt <= 1'b1;
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    {in_sysmgmt, in_enclave} <= 2'b01;
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    in_enclave <= 1'b0;
    wr(OFF_DBG, 32'h0000_0002);
    ap(1'b0, OFF_DBG, '0, 32'h0000_0002, 1'b0);
    tx(3'd2, CAT_OTHER, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, 32'h007E_0001);
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    for (int j = 6; j < 8; j++) tx(3'd0, 4'(j), 1'b0, 1'b0, 1'b0);
    ce;
    ap(1'b0, OFF_LER_SRC, '0, le.s, 1'b0);
    ap(1'b0, OFF_LER_META, '0, {28'h0, le.c}, 1'b0);
    $display("test record done");
    ap(1'b1, OFF_DEPTH, 32'h0000_0000, '0, 1'b1);
    ap(1'b1, OFF_DEPTH, 32'h0000_0009, '0, 1'b1);
    wr(OFF_DEPTH, 32'h0000_0004);
    dep = 4;
    clr;
    ce;
    ap(1'b0, OFF_LER_DST, '0, le.d, 1'b0);
    repeat (6) tx(3'd0, CAT_REL_JMP, 1'b0, 1'b0, 1'b1);
    ce;
    wr(OFF_SEL, 32'h0000_0004);
    ap(1'b0, OFF_SEL, '0, 32'h0000_0004, 1'b0);
    ap(1'b0, OFF_SRC, '0, '0, 1'b1);
    ap(1'b1, OFF_DST, 32'h1234_5678, '0, 1'b1);
    $display("test depth done");
    cs = 1'b1;
    wr(OFF_CTL, 32'h0038_0009);
    repeat (3) tx(3'd0, CAT_REL_CALL, 1'b0, 1'b0, 1'b1);
    tx(3'd0, CAT_IND_CALL, 1'b0, 1'b0, 1'b1);
    repeat (2) tx(3'd0, CAT_RET, 1'b0, 1'b0, 1'b1);
    ce;
    $display("test call stack done");
    cs = 1'b0;
    wr(OFF_CTL, 32'h007F_0001);
    wr(OFF_DBG, 32'h0000_0001);
    perf_irq_pend <= 1'b1;
    @(posedge clk_sys);
    perf_irq_pend <= 1'b0;
    @(posedge clk_sys);
    chk({31'h0, record_frozen_flag}, 32'h0000_0001);
    perf_irq_pend <= 1'b1;
    wr(OFF_STS, 32'h0000_0001);
    perf_irq_pend <= 1'b0;
    ap(1'b0, OFF_STS, '0, 32'h0000_0001, 1'b0);
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    wr(OFF_STS, 32'h0000_0001);
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b1);
    ce;
    $display("test freeze done");
    tx(3'd3, CAT_OTHER, 1'b0, 1'b0, 1'b0);
    chk({31'h0, record_enable}, 32'h0000_0000);
    tx(3'd0, CAT_FLAG_TEST_BRANCH, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTL, 32'h007F_0009);
    tx(3'd7, CAT_OTHER, 1'b0, 1'b0, 1'b0);
    ap(1'b0, OFF_CTL, '0, '0, 1'b0);
    wr(OFF_SEL, 32'h0000_0001);
    ap(1'b1, OFF_DST, 32'h5a5a_0f0f, '0, 1'b0);
    me[1].d = 32'h5a5a_0f0f;
    ap(1'b1, OFF_LER_META, 32'h0000_0003, '0, 1'b0);
    ap(1'b0, OFF_LER_META, '0, 32'h0000_0003, 1'b0);
    ce;
    $display("test clear done");
    results;
  end
endmodule
`default_nettype wire
